// >>> bench/prtcd_ext_model.sv
// Far-side model: source of the two capture input pins
`timescale 1ns/1ps
module prtcd_ext_model (
    input wire logic hclk,
    output logic [1:0] capture_input_pin
);
    // Idle levels: channel 0 low, channel 1 high
    initial begin
        capture_input_pin = 2'b10;
    end

    // Moves one pin just after a rising edge, like a synchronous source
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge hclk);
        capture_input_pin[ch] <= lvl;
    endtask
endmodule // prtcd_ext_model

// >>> bench/tb_top.sv
// Testbench: register, capture and PWM sequences for the capture/duty block
`timescale 1ns/1ps
module tb_top
    import prtcd_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic halt_mode, capture_irq, halt_wakeup, p0, hit;
    logic [31:0] haddr, hwdata, hrdata, rd, cnt_v;
    logic [1:0] htrans, cap_pins;
    logic [2:0] hsize;
    logic [3:0] pwm_out;
    int miscompares = 0;
    int check_count = 0;
    int n;
    int hi [4];
    logic [7:0] duty_tbl [4] = '{8'hf8, 8'hfc, 8'hf0, 8'h40};
    int hi_exp [4] = '{9, 13, 1, 16};

    // ------------------------------------------------------------
    // Clock, bus ready loop-back, instances
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    assign hready = hreadyout;

    prtcd_ext_model i_ext (.hclk(hclk), .capture_input_pin(cap_pins));

    prtcd_top #(.NUM_PWM(4)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .capture_input_pin(cap_pins), .halt_mode(halt_mode),
        .capture_irq(capture_irq), .halt_wakeup(halt_wakeup), .pwm_out(pwm_out)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus master tasks
    // ------------------------------------------------------------
    // Bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 100);
        if (k >= 100) begin
            chk("bus wait", 32'h1, 32'h0);
            end_sim();
        end
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk(name, rd, e);
    endtask

    // Pin change, then time for detection and flag update
    task automatic pin(input int ch, input logic lvl);
        i_ext.set_pin(ch, lvl);
        repeat (3) @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        halt_mode = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, unmapped place, reserved bits
        rdchk("csr reset", IDX_CSR, 32'h0);
        chk("hresp okay", {31'h0, hresp}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rdchk("duty reset", 6'(IDX_DUTY0 + i), {24'h0, DUTY_RST});
        end
        rdchk("arr reset", IDX_ARR, {24'h0, ARR_RST});
        wr(IDX_NONE, 32'hff);
        rdchk("unmapped", IDX_NONE, 32'h0);
        wr(IDX_CSR, 32'hff);
        rdchk("csr reserved", IDX_CSR, 32'h3c);
        // Duty registers written one by one, read back after all writes
        for (int i = 0; i < 4; i++) begin
            wr(6'(IDX_DUTY0 + i), {24'h0, duty_tbl[i]});
        end
        for (int i = 0; i < 4; i++) begin
            rdchk("duty value", 6'(IDX_DUTY0 + i), {24'h0, duty_tbl[i]});
        end
        // Ch0 rising, ch1 falling, both enabled; counter stopped at zero
        wr(IDX_CSR, 32'h1c);
        pin(0, 1'b1);
        rdchk("flag0 set", IDX_CSR, 32'h1d);
        chk("irq ch0", {31'h0, capture_irq}, 32'h1);
        chk("no wakeup running", {31'h0, halt_wakeup}, 32'h0);
        rdchk("capture0", IDX_CAPV0, 32'h0);
        rdchk("flag0 cleared", IDX_CSR, 32'h1c);
        chk("irq cleared", {31'h0, capture_irq}, 32'h0);
        pin(0, 1'b0);
        rdchk("falling ignored", IDX_CSR, 32'h1c);
        pin(1, 1'b0);
        rdchk("flag1 set", IDX_CSR, 32'h1e);
        chk("irq ch1", {31'h0, capture_irq}, 32'h1);
        rdchk("capture1", IDX_CAPV1, 32'h0);
        // Enable off: flag still set, request held low
        wr(IDX_CSR, 32'h10);
        pin(0, 1'b1);
        rdchk("flag no irq", IDX_CSR, 32'h11);
        chk("irq gated", {31'h0, capture_irq}, 32'h0);
        rdchk("capture0 again", IDX_CAPV0, 32'h0);
        // Selects swapped: ch0 falling, ch1 rising, enables off
        wr(IDX_CSR, 32'h20);
        pin(0, 1'b0);
        pin(1, 1'b1);
        rdchk("edges swapped", IDX_CSR, 32'h23);
        rdchk("capture0 falling", IDX_CAPV0, 32'h0);
        rdchk("capture1 rising", IDX_CAPV1, 32'h0);
        pin(0, 1'b1);
        rdchk("rising ignored", IDX_CSR, 32'h20);
        // PWM: reload 0xf0, period of 16 counts
        wr(IDX_ARR, 32'hf0);
        wr(IDX_CTRL, 32'h1);
        rdchk("arr value", IDX_ARR, 32'hf0);
        rdchk("ctrl value", IDX_CTRL, 32'h1);
        p0 = 1'b1;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
            hit = (p0 === 1'b0) && (pwm_out[0] === 1'b1);
            p0 = pwm_out[0];
        end while (!hit && n < 1000);
        chk("pwm start", {31'h0, hit}, 32'h1);
        chk("pwm first edge", {28'h0, pwm_out}, 32'hf);
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 4; j++) begin
                if (pwm_out[j] === 1'b1) begin
                    hi[j]++;
                end
            end
            @(negedge hclk);
        end
        for (int j = 0; j < 4; j++) begin
            chk("pwm high count", 32'(hi[j]), 32'(hi_exp[j]));
        end
        // Halt: counter frozen, enabled capture still requests
        @(posedge hclk);
        halt_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, IDX_CNT, 32'h0);
        cnt_v = rd;
        chk("counter range", {31'h0, cnt_v[31:8] == 24'h0 && cnt_v[7:0] >= 8'hf0}, 32'h1);
        rdchk("counter frozen", IDX_CNT, cnt_v);
        wr(IDX_CSR, 32'h1c);
        pin(0, 1'b0);
        pin(0, 1'b1);
        rdchk("halt flag", IDX_CSR, 32'h1d);
        chk("halt wakeup", {31'h0, halt_wakeup}, 32'h1);
        rdchk("halt capture", IDX_CAPV0, cnt_v);
        end_sim();
    end
endmodule // tb_top

// >>> core/prtcd_capture.sv
// One input-capture channel: edge detector and captured counter value
`timescale 1ns/1ps
module prtcd_capture
    import prtcd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic capture_input_pin,
    input wire logic capture_edge_select,
    input wire logic [7:0] counter,
    output logic event_p,
    output logic [7:0] value
);

    typedef struct packed {
        logic armed;
        logic prev;
        logic [7:0] value;
    } prtcd_cap_state_t;

    prtcd_cap_state_t st_q;
    prtcd_cap_state_t st_d;

    // Edge detect; armed blocks a false edge from the reset-time sample
    always_comb begin
        st_d = st_q;
        st_d.armed = 1'b1;
        st_d.prev = capture_input_pin;
        event_p = st_q.armed && (capture_edge_select ?
            (capture_input_pin && !st_q.prev) :
            (!capture_input_pin && st_q.prev));
        if (event_p) begin
            st_d.value = counter;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.value;

endmodule // prtcd_capture

// >>> core/prtcd_pkg.sv
// Package: register map, field positions and reset values of the capture/duty block
package prtcd_pkg;

    // ------------------------------------------------------------
    // Register word indexes (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CSR = 6'h00;
    localparam logic [5:0] IDX_CAPV0 = 6'h01;
    localparam logic [5:0] IDX_CAPV1 = 6'h02;
    localparam logic [5:0] IDX_ARR = 6'h03;
    localparam logic [5:0] IDX_CTRL = 6'h04;
    localparam logic [5:0] IDX_CNT = 6'h05;
    localparam logic [5:0] IDX_DUTY0 = 6'h08;
    localparam logic [5:0] IDX_NONE = 6'h3f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CSR_CS_LSB = 4;
    localparam int CSR_CIE_LSB = 2;
    localparam int CSR_CF_LSB = 0;
    localparam int CTRL_EN_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [1:0] CSR_FIELD_RST = 2'h0;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] ARR_RST = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam int MAX_PWM = 8;

endpackage

// >>> core/prtcd_pwm_chan.sv
// One PWM channel: set on counter reload, cleared on duty compare
`timescale 1ns/1ps
module prtcd_pwm_chan
    import prtcd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reload,
    input wire logic running,
    input wire logic [7:0] counter,
    input wire logic [7:0] duty_value,
    output logic pwm_out
);

    typedef struct packed {
        logic out;
    } prtcd_pwm_state_t;

    prtcd_pwm_state_t st_q;
    prtcd_pwm_state_t st_d;

    // First edge shared at reload, second edge at this channel's duty
    always_comb begin
        st_d = st_q;
        if (reload) begin
            st_d.out = 1'b1;
        end else if (running && counter == duty_value) begin
            st_d.out = 1'b0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pwm_out = st_q.out;

endmodule // prtcd_pwm_chan

// >>> core/prtcd_top.sv
// Auto-reload PWM timer: duty compare registers and two-channel input capture
// Operation
// - Selected capture edge raises capture interrupt request
// - Edge select: 0 falling, 1 rising
// - Per-channel interrupt enable gates its request
// - Capture sets flag; reading capture value clears
// - Enabled capture still interrupts during halt
// - Control/status bits 7:6 read zero
// - Control/status register resets to zero
// - Per-channel 8-bit duty register, reset zero
// - First PWM edge common, at reload
// - Duty registers act independently per channel
`timescale 1ns/1ps
module prtcd_top
    import prtcd_pkg::*;
#(
    parameter int NUM_PWM = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] capture_input_pin,
    input wire logic halt_mode,
    output logic capture_irq,
    output logic halt_wakeup,
    output logic [NUM_PWM-1:0] pwm_out
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_PWM < 1 || NUM_PWM > MAX_PWM) begin : g_bad_param
        $error("NUM_PWM must lie between 1 and 8");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic [1:0] capture_irq_enable_field;
        logic [1:0] capture_event_flag_field;
        logic [NUM_PWM-1:0][7:0] duty_value;
        logic [7:0] auto_reload;
        logic [7:0] count;
        logic count_en;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] rdata;
    } prtcd_state_t;

    prtcd_state_t st_q;
    prtcd_state_t st_d;
    logic bus_acc;
    logic [5:0] bus_idx;
    logic running;
    logic cnt_reload;
    logic [1:0] cap_evt;
    logic [1:0][7:0] cap_val;

    // Address phase decode; only the low 256 bytes are mapped
    assign bus_acc = hsel && htrans[1] && hready;
    assign bus_idx = (haddr[31:8] == 24'h000000) ? haddr[7:2] : IDX_NONE;

    // Counter stops while the device is halted
    assign running = st_q.count_en && !halt_mode;
    assign cnt_reload = running && st_q.count == CNT_TOP;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Free-running up counter with auto-reload
        if (running) begin
            st_d.count = cnt_reload ? st_q.auto_reload : 8'(st_q.count + 8'h01);
        end
        // Data phase of a write
        if (st_q.wr_pend) begin
            case (st_q.wr_idx)
                IDX_CSR: begin
                    st_d.capture_edge_select = hwdata[CSR_CS_LSB +: 2];
                    st_d.capture_irq_enable_field = hwdata[CSR_CIE_LSB +: 2];
                end
                IDX_ARR: begin
                    st_d.auto_reload = hwdata[7:0];
                end
                IDX_CTRL: begin
                    st_d.count_en = hwdata[CTRL_EN_BIT];
                end
                default: begin
                    // Each duty register touches only its own channel
                    for (int i = 0; i < NUM_PWM; i++) begin
                        if (st_q.wr_idx == IDX_DUTY0 + 6'(i)) begin
                            st_d.duty_value[i] = hwdata[7:0];
                        end
                    end
                end
            endcase
        end
        // Address phase capture
        st_d.wr_pend = bus_acc && hwrite;
        st_d.wr_idx = bus_idx;
        // Reading a capture value clears its flag
        if (bus_acc && !hwrite && bus_idx == IDX_CAPV0) begin
            st_d.capture_event_flag_field[0] = 1'b0;
        end
        if (bus_acc && !hwrite && bus_idx == IDX_CAPV1) begin
            st_d.capture_event_flag_field[1] = 1'b0;
        end
        // Capture event sets its flag; set wins over a same-cycle clear
        for (int c = 0; c < 2; c++) begin
            if (cap_evt[c]) begin
                st_d.capture_event_flag_field[c] = 1'b1;
            end
        end
        // Read data, forwarded from the updated state; counter and capture values are read from the current state
        if (bus_acc && !hwrite) begin
            st_d.rdata = 32'h00000000;
            case (bus_idx)
                IDX_CSR: begin
                    st_d.rdata[7:0] = {2'b00, st_d.capture_edge_select,
                        st_d.capture_irq_enable_field,
                        st_d.capture_event_flag_field};
                end
                IDX_CAPV0: begin
                    st_d.rdata[7:0] = cap_val[0];
                end
                IDX_CAPV1: begin
                    st_d.rdata[7:0] = cap_val[1];
                end
                IDX_ARR: begin
                    st_d.rdata[7:0] = st_d.auto_reload;
                end
                IDX_CTRL: begin
                    st_d.rdata[CTRL_EN_BIT] = st_d.count_en;
                end
                IDX_CNT: begin
                    st_d.rdata[7:0] = st_q.count;
                end
                default: begin
                    for (int i = 0; i < NUM_PWM; i++) begin
                        if (bus_idx == IDX_DUTY0 + 6'(i)) begin
                            st_d.rdata[7:0] = st_d.duty_value[i];
                        end
                    end
                end
            endcase
        end
    end

    // State register, all fields cleared at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    // Request stays up while an enabled flag is set, halted or not
    assign capture_irq = |(st_q.capture_event_flag_field
        & st_q.capture_irq_enable_field);
    assign halt_wakeup = halt_mode && capture_irq;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_cap
        prtcd_capture u_cap (
            .hclk(hclk),
            .hresetn(hresetn),
            .capture_input_pin(capture_input_pin[c]),
            .capture_edge_select(st_q.capture_edge_select[c]),
            .counter(st_q.count),
            .event_p(cap_evt[c]),
            .value(cap_val[c])
        );
    end

    for (genvar p = 0; p < NUM_PWM; p++) begin : g_pwm
        prtcd_pwm_chan u_pwm (
            .hclk(hclk),
            .hresetn(hresetn),
            .reload(cnt_reload),
            .running(running),
            .counter(st_q.count),
            .duty_value(st_q.duty_value[p]),
            .pwm_out(pwm_out[p])
        );
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic alive_q;

    // Marks the edge detectors as armed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alive_q <= 1'b0;
        end else begin
            alive_q <= 1'b1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    rise_flag_a: assert property (alive_q && $rose(capture_input_pin[0])
        && st_q.capture_edge_select[0] |=> st_q.capture_event_flag_field[0])
        else $error("rising edge did not set flag");
    fall_flag_a: assert property (alive_q && $fell(capture_input_pin[1])
        && !st_q.capture_edge_select[1] |=> st_q.capture_event_flag_field[1])
        else $error("falling edge did not set flag");
    wrong_edge_a: assert property (alive_q && $rose(capture_input_pin[0])
        && !st_q.capture_edge_select[0] |-> !cap_evt[0])
        else $error("capture on unselected edge");
    read_clear_a: assert property (bus_acc && !hwrite && bus_idx == IDX_CAPV0
        && !cap_evt[0] |=> !st_q.capture_event_flag_field[0])
        else $error("capture value read left flag set");
    irq_raise_a: assert property (cap_evt[1] && st_q.capture_irq_enable_field[1]
        |=> capture_irq)
        else $error("enabled capture raised no request");
    irq_masked_a: assert property (st_q.capture_irq_enable_field == 2'b00
        |-> !capture_irq)
        else $error("request with enables clear");
    halt_wake_a: assert property (halt_mode && cap_evt[0]
        && st_q.capture_irq_enable_field[0] ##1 halt_mode |-> halt_wakeup)
        else $error("no wakeup in halt");
    reserved_zero_a: assert property (bus_acc && !hwrite && bus_idx == IDX_CSR
        |=> hrdata[7:6] == 2'b00 && hrdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");
    reset_csr_a: assert property ($rose(hresetn) |-> st_q.capture_edge_select == 2'b00
        && st_q.capture_irq_enable_field == 2'b00
        && st_q.capture_event_flag_field == 2'b00)
        else $error("control/status not cleared by reset");
    cap_value_a: assert property (cap_evt[0] |=> cap_val[0] == $past(st_q.count))
        else $error("captured value wrong");
    pwm_reload_a: assert property (cnt_reload |=> pwm_out[0]
        && st_q.count == $past(st_q.auto_reload))
        else $error("reload did not start PWM period");
    duty_indep_a: assert property (NUM_PWM > 1 && st_q.wr_pend
        && st_q.wr_idx == IDX_DUTY0 |=> $stable(st_q.duty_value[NUM_PWM-1]))
        else $error("duty write disturbed another channel");

    // Flags move only by a capture or by a capture-value read
    flag_hold_a: assert property (st_q.capture_event_flag_field[0]
        && !(bus_acc && !hwrite && bus_idx == IDX_CAPV0) |=> st_q.capture_event_flag_field[0])
        else $error("flag cleared without capture value read");
    flag_source_a: assert property (!st_q.capture_event_flag_field[1]
        && !cap_evt[1] |=> !st_q.capture_event_flag_field[1])
        else $error("flag set without capture");
    // Captured value holds between events
    cap_hold_a: assert property (!cap_evt[1]
        |=> $stable(cap_val[1]))
        else $error("capture value changed without event");
    // Wakeup only while halted
    wake_gate_a: assert property (!halt_mode
        |-> !halt_wakeup)
        else $error("wakeup outside halt");
    // Duty registers: reset value and write landing
    duty_reset_a: assert property ($rose(hresetn)
        |-> st_q.duty_value == '0)
        else $error("duty register not cleared by reset");
    duty_write_a: assert property (st_q.wr_pend && st_q.wr_idx == IDX_DUTY0
        |=> st_q.duty_value[0] == $past(hwdata[7:0]))
        else $error("duty write did not land");
    // PWM: all channels start together, channel 0 clears at its match
    reload_all_a: assert property (cnt_reload
        |=> &pwm_out)
        else $error("reload did not set every output");
    pwm_match_a: assert property (running && !cnt_reload
        && st_q.count == st_q.duty_value[0] |=> !pwm_out[0])
        else $error("duty match did not clear output");

    capture_seen_c: cover property (cap_evt[0] ##1 st_q.capture_event_flag_field[0]);
    halt_wake_c: cover property (halt_mode ##1 halt_wakeup);
    reload_c: cover property (cnt_reload ##1 pwm_out[0]);
    read_clear_c: cover property (bus_acc && !hwrite && bus_idx == IDX_CAPV1
        && st_q.capture_event_flag_field[1]);
    duty_clear_c: cover property (running && st_q.count == st_q.duty_value[0] ##1 !pwm_out[0]);

endmodule // prtcd_top
